// ### common/flash_front_pkg.sv
package flash_front_pkg;
   // Field widths of the command and address stream.
   localparam int OPC_W = 8;
   localparam int PAGE_W = 10;
   localparam int BYTE_W = 9;
   localparam int LIN_W = 18;
   localparam int ADDR_W = 24;
   // Bit positions inside the 24-bit address word.
   localparam int PAGE_LSB_264 = 9;
   localparam int BYTE_LSB_264 = 0;
   localparam int PAGE_LSB_256 = 8;
   localparam int BYTE_LSB_256 = 0;
   localparam int LIN_LSB = 0;
   // Byte counts that follow an opcode.
   localparam logic [2:0] ADDR_BYTES = 3'h3;
   localparam logic [2:0] DUMMY_NONE = 3'h0;
   localparam logic [2:0] DUMMY_ONE = 3'h1;
   localparam logic [2:0] DUMMY_FOUR = 3'h4;
   // Page field masks for the partial page commands.
   localparam logic [PAGE_W-1:0] PAGE_MASK_UPPER6 = 10'h3F0;
   localparam logic [PAGE_W-1:0] PAGE_MASK_TOP = 10'h200;
   // Opcodes understood by the front end.
   localparam logic [7:0] OP_ARRAY_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
   localparam logic [7:0] OP_PAGE_TO_BUF = 8'h53;
   localparam logic [7:0] OP_AUTO_REWRITE = 8'h58;
   localparam logic [7:0] OP_PAGE_COMPARE = 8'h60;
   localparam logic [7:0] OP_SECURITY_READ = 8'h77;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
   localparam logic [7:0] OP_PROG_THRU_BUF = 8'h82;
   localparam logic [7:0] OP_BUF_PROG_ERASE = 8'h83;
   localparam logic [7:0] OP_BUF_WRITE = 8'h84;
   localparam logic [7:0] OP_BUF_PROG = 8'h88;
   localparam logic [7:0] OP_ID_READ = 8'h9F;
   localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
   localparam logic [7:0] OP_RESUME = 8'hAB;
   localparam logic [7:0] OP_BUF_READ_SLOW = 8'hD1;
   localparam logic [7:0] OP_PAGE_READ = 8'hD2;
   localparam logic [7:0] OP_BUF_READ_FAST = 8'hD4;
   localparam logic [7:0] OP_STATUS_READ = 8'hD7;
   localparam logic [7:0] OP_CONT_READ = 8'hE8;
   // Power-up timing.
   localparam int CLK_MHZ = 250;
   localparam int SELECT_DELAY_MS = 1;
   localparam int WRITE_DELAY_MS = 20;
   localparam int WRITE_DELAY_CYCLES = WRITE_DELAY_MS * 1000 * CLK_MHZ;
   // Reset values.
   localparam logic MODE3_RESET = 1'b1;
   localparam logic SO_OE_N_RESET = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_IGNORE
   } state_type;

   typedef enum logic [2:0] {
      FLD_FULL,
      FLD_PAGE,
      FLD_PAGE6,
      FLD_PAGE1,
      FLD_BUFFER,
      FLD_NONE
   } field_type;
endpackage

// ### rtl/sck_byte_shifter.sv
`timescale 1ns/1ps
module sck_byte_shifter #(
   parameter int BYTE_W = 8
) (
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic srst_i,
   input wire logic si_i,
   output logic [BYTE_W-1:0] byte_o,
   output logic byte_tog_o
);
   localparam int CNT_W = $clog2(BYTE_W);
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(BYTE_W - 1);

   logic [CNT_W-1:0] bit_cnt;
   logic [CNT_W-1:0] next_bit_cnt;
   logic [BYTE_W-1:0] shift;
   logic [BYTE_W-1:0] next_shift;
   logic [BYTE_W-1:0] next_byte;
   logic next_tog;

   // Modes 0 and 3 both sample input on the rising clock edge, most
   // significant bit first, so one shifter serves either mode.
   always_comb
   begin
      next_shift = {shift[BYTE_W-2:0], si_i};
      next_bit_cnt = bit_cnt + 1'b1;
      next_byte = byte_o;
      next_tog = byte_tog_o;
      if (bit_cnt == LAST_BIT)
      begin
         next_bit_cnt = '0;
         next_byte = next_shift;
         next_tog = ~byte_tog_o;
      end
   end

   // A deselect clears the bit position; the clock may stop while idle.
   always_ff @(posedge sck_i or posedge cs_n_i)
   begin
      if (cs_n_i)
      begin
         bit_cnt <= '0;
         shift <= '0;
      end
      else
      begin
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
      end
   end

   // The toggle is never cleared by deselect, else it would fake a byte.
   always_ff @(posedge sck_i or posedge srst_i)
   begin
      if (srst_i)
      begin
         byte_o <= '0;
         byte_tog_o <= 1'b0;
      end
      else
      begin
         byte_o <= next_byte;
         byte_tog_o <= next_tog;
      end
   end
endmodule

// ### rtl/flash_cmd_front.sv
`timescale 1ns/1ps
// Overview of operation
// - 264-byte pages: 5 reserved bits, 10-bit page, 9-bit byte address.
// - Page commands use page only; 50h upper six bits, 7Ch top bit.
// - Buffer commands 84h, D1h, D4h use only the 9-bit byte field.
// - 0Bh, D4h take one dummy byte; D2h, E8h four; 77h ignores address.
// - After reset assume clock mode 3 and keep serial output high-Z.
// - Accept an instruction only after a chip select falling edge.
// - Each select falling edge samples idle clock level to pick mode.
// - While power-on reset holds, ignore all commands.
// - Refuse program or erase until 20 ms after reset release.
// - After power-up the device rests in standby, ready for a command.
// - 256-byte pages: 6 reserved bits then 18-bit linear byte address.
module flash_cmd_front
   import flash_front_pkg::*;
#(
   parameter int WRITE_DELAY = flash_front_pkg::WRITE_DELAY_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic page_size_256_i,
   output logic so_o,
   output logic so_oe_n_o,
   output logic mode3_o,
   output logic cmd_valid_o,
   output logic [flash_front_pkg::OPC_W-1:0] opcode_o,
   output logic [flash_front_pkg::PAGE_W-1:0] page_o,
   output logic [flash_front_pkg::BYTE_W-1:0] byte_o,
   output logic [flash_front_pkg::LIN_W-1:0] linear_addr_o,
   output logic data_phase_o,
   output logic write_allowed_o,
   output logic write_refused_o
);
   import flash_front_pkg::*;

   localparam int WCNT_W = $clog2(WRITE_DELAY + 1);
   localparam logic [WCNT_W-1:0] WCNT_END = WCNT_W'(WRITE_DELAY);

   logic [OPC_W-1:0] link_byte;
   logic link_tog;
   logic cs_s1, cs_s2, sck_s1, sck_s2, tog_s1, tog_s2, tog_s3;
   logic cs_prev;
   logic cs_fall, cs_rise, new_byte;
   state_type state, next_state;
   logic [2:0] cnt, next_cnt;
   logic [ADDR_W-1:0] addr, next_addr;
   logic next_mode3, next_cmd_valid, next_write_refused;
   logic [OPC_W-1:0] next_opcode;
   logic [PAGE_W-1:0] next_page;
   logic [BYTE_W-1:0] next_byte;
   logic [LIN_W-1:0] next_linear;
   logic [WCNT_W-1:0] wcnt, next_wcnt;

   // Bit assembly runs on the serial clock; only whole bytes cross over.
   sck_byte_shifter #(.BYTE_W(OPC_W)) shifter (
      .sck_i(sck_i),
      .cs_n_i(cs_n_i),
      .srst_i(srst_i),
      .si_i(si_i),
      .byte_o(link_byte),
      .byte_tog_o(link_tog)
   );

   // Classification of each opcode.
   function automatic logic known_op(input logic [OPC_W-1:0] op);
      case (op)
         OP_ARRAY_READ, OP_FAST_READ, OP_BLOCK_ERASE, OP_PAGE_TO_BUF,
         OP_AUTO_REWRITE, OP_PAGE_COMPARE, OP_SECURITY_READ,
         OP_SECTOR_ERASE, OP_PAGE_ERASE, OP_PROG_THRU_BUF,
         OP_BUF_PROG_ERASE, OP_BUF_WRITE, OP_BUF_PROG, OP_ID_READ,
         OP_POWER_DOWN, OP_RESUME, OP_BUF_READ_SLOW, OP_PAGE_READ,
         OP_BUF_READ_FAST, OP_STATUS_READ, OP_CONT_READ: known_op = 1'b1;
         default: known_op = 1'b0;
      endcase
   endfunction

   function automatic logic no_addr_op(input logic [OPC_W-1:0] op);
      no_addr_op = (op == OP_STATUS_READ) || (op == OP_ID_READ) ||
         (op == OP_POWER_DOWN) || (op == OP_RESUME);
   endfunction

   function automatic logic [2:0] dummy_of(input logic [OPC_W-1:0] op);
      case (op)
         OP_FAST_READ, OP_BUF_READ_FAST: dummy_of = DUMMY_ONE;
         OP_PAGE_READ, OP_CONT_READ: dummy_of = DUMMY_FOUR;
         default: dummy_of = DUMMY_NONE;
      endcase
   endfunction

   function automatic field_type field_of(input logic [OPC_W-1:0] op);
      case (op)
         OP_PAGE_TO_BUF, OP_AUTO_REWRITE, OP_PAGE_COMPARE, OP_PAGE_ERASE,
         OP_BUF_PROG_ERASE, OP_BUF_PROG: field_of = FLD_PAGE;
         OP_BLOCK_ERASE: field_of = FLD_PAGE6;
         OP_SECTOR_ERASE: field_of = FLD_PAGE1;
         OP_BUF_WRITE, OP_BUF_READ_SLOW,
         OP_BUF_READ_FAST: field_of = FLD_BUFFER;
         OP_SECURITY_READ: field_of = FLD_NONE;
         default: field_of = FLD_FULL;
      endcase
   endfunction

   function automatic logic write_op(input logic [OPC_W-1:0] op);
      case (op)
         OP_BLOCK_ERASE, OP_AUTO_REWRITE, OP_SECTOR_ERASE, OP_PAGE_ERASE,
         OP_PROG_THRU_BUF, OP_BUF_PROG_ERASE, OP_BUF_PROG: write_op = 1'b1;
         default: write_op = 1'b0;
      endcase
   endfunction

   // Select, clock and the byte toggle pass two flops before any logic reads them.
   always_ff @(posedge ref_clk_i)
   begin
      cs_s1 <= cs_n_i;
      cs_s2 <= cs_s1;
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      tog_s1 <= link_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
   end

   // Select and clock share the same sync depth, so at a select edge the
   // clock level seen is still its idle level.
   assign cs_fall = cs_prev & ~cs_s2;
   assign cs_rise = ~cs_prev & cs_s2;
   assign new_byte = tog_s2 ^ tog_s3;

   // The write hold-off counter starts when reset is released.
   always_comb
   begin
      next_wcnt = wcnt;
      if (wcnt != WCNT_END)
      begin
         next_wcnt = wcnt + 1'b1;
      end
   end

   // Command sequencer: opcode, address bytes, dummy bytes, then data.
   always_comb
   begin
      logic issue;
      logic [PAGE_W-1:0] pg;
      logic [BYTE_W-1:0] by;
      issue = 1'b0;
      pg = '0;
      by = '0;
      next_state = state;
      next_cnt = cnt;
      next_addr = addr;
      next_mode3 = mode3_o;
      next_opcode = opcode_o;
      next_page = page_o;
      next_byte = byte_o;
      next_linear = linear_addr_o;
      next_cmd_valid = 1'b0;
      next_write_refused = 1'b0;
      if (cs_fall)
      begin
         next_mode3 = sck_s2;
      end
      case (state)
         ST_IDLE:
         begin
            if (cs_fall)
            begin
               next_state = ST_OPCODE;
            end
         end
         ST_OPCODE:
         begin
            if (new_byte)
            begin
               next_opcode = link_byte;
               next_addr = '0;
               next_cnt = '0;
               if (!known_op(link_byte))
               begin
                  next_state = ST_IGNORE;
               end
               else if (no_addr_op(link_byte))
               begin
                  issue = 1'b1;
               end
               else
               begin
                  next_state = ST_ADDR;
               end
            end
         end
         ST_ADDR:
         begin
            if (new_byte)
            begin
               next_addr = {addr[ADDR_W-OPC_W-1:0], link_byte};
               next_cnt = cnt + 1'b1;
               if (next_cnt == ADDR_BYTES)
               begin
                  next_cnt = '0;
                  if (dummy_of(opcode_o) == DUMMY_NONE)
                  begin
                     issue = 1'b1;
                  end
                  else
                  begin
                     next_state = ST_DUMMY;
                  end
               end
            end
         end
         ST_DUMMY:
         begin
            if (new_byte)
            begin
               next_cnt = cnt + 1'b1;
               if (next_cnt == dummy_of(opcode_o))
               begin
                  issue = 1'b1;
               end
            end
         end
         ST_DATA, ST_IGNORE:
         begin
            next_state = state;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
      if (issue)
      begin
         if (page_size_256_i)
         begin
            pg = next_addr[PAGE_LSB_256 +: PAGE_W];
            by = {1'b0, next_addr[BYTE_LSB_256 +: OPC_W]};
         end
         else
         begin
            pg = next_addr[PAGE_LSB_264 +: PAGE_W];
            by = next_addr[BYTE_LSB_264 +: BYTE_W];
         end
         next_linear = next_addr[LIN_LSB +: LIN_W];
         case (field_of(next_opcode))
            FLD_PAGE: by = '0;
            FLD_PAGE6:
            begin
               pg = pg & PAGE_MASK_UPPER6;
               by = '0;
            end
            FLD_PAGE1:
            begin
               pg = pg & PAGE_MASK_TOP;
               by = '0;
            end
            FLD_BUFFER: pg = '0;
            FLD_NONE:
            begin
               pg = '0;
               by = '0;
               next_linear = '0;
            end
            default: pg = pg;
         endcase
         next_page = pg;
         next_byte = by;
         if (write_op(next_opcode) && !write_allowed_o)
         begin
            next_write_refused = 1'b1;
            next_state = ST_IGNORE;
         end
         else
         begin
            next_cmd_valid = 1'b1;
            next_state = ST_DATA;
         end
      end
      if (cs_rise)
      begin
         next_state = ST_IDLE;
         next_cnt = '0;
      end
   end

   // Reset holds everything idle; cs_prev starts low so a select that is
   // already low at release is not taken as a falling edge.
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         state <= ST_IDLE;
         cs_prev <= 1'b0;
         cnt <= '0;
         addr <= '0;
         mode3_o <= MODE3_RESET;
         opcode_o <= '0;
         page_o <= '0;
         byte_o <= '0;
         linear_addr_o <= '0;
         cmd_valid_o <= 1'b0;
         write_refused_o <= 1'b0;
         wcnt <= '0;
         write_allowed_o <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cs_prev <= cs_s2;
         cnt <= next_cnt;
         addr <= next_addr;
         mode3_o <= next_mode3;
         opcode_o <= next_opcode;
         page_o <= next_page;
         byte_o <= next_byte;
         linear_addr_o <= next_linear;
         cmd_valid_o <= next_cmd_valid;
         write_refused_o <= next_write_refused;
         wcnt <= next_wcnt;
         write_allowed_o <= (next_wcnt == WCNT_END);
      end
   end

   // This front end returns no data, so the output stays released.
   assign so_o = 1'b0;
   assign so_oe_n_o = SO_OE_N_RESET;
   assign data_phase_o = (state == ST_DATA);

   sequence seq_opcode_nodata;
      state == ST_OPCODE && new_byte && link_byte == OP_STATUS_READ;
   endsequence

   chk_reset_mode3: assert property (@(posedge ref_clk_i)
      srst_i |=> mode3_o && so_oe_n_o)
      else $error("mode 3 or high-Z output missing after reset");
   chk_mode_pick: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) cs_fall |=> mode3_o == $past(sck_s2))
      else $error("clock mode not taken from idle clock level");
   chk_reset_quiet: assert property (@(posedge ref_clk_i)
      srst_i |=> !cmd_valid_o && !write_refused_o && state == ST_IDLE)
      else $error("command activity during reset");
   chk_page_only: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) cmd_valid_o && field_of(opcode_o) != FLD_FULL
      && field_of(opcode_o) != FLD_BUFFER |-> byte_o == '0)
      else $error("byte field not ignored for page command");
   chk_buffer_only: assert property (@(posedge ref_clk_i)
      disable iff (srst_i)
      cmd_valid_o && field_of(opcode_o) == FLD_BUFFER |-> page_o == '0)
      else $error("page field not ignored for buffer command");
   chk_field_split: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) cmd_valid_o && !page_size_256_i &&
      opcode_o == OP_ARRAY_READ |-> {page_o, byte_o} == addr[18:0])
      else $error("page and byte split wrong for 264-byte pages");
   chk_write_hold: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) cmd_valid_o && write_op(opcode_o)
      |-> $past(write_allowed_o))
      else $error("write command accepted during hold-off");
   chk_dummy_count: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) cmd_valid_o && dummy_of(opcode_o) != DUMMY_NONE
      |-> $past(state) == ST_DUMMY)
      else $error("data phase reached without dummy bytes");
   chk_no_addr: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) seq_opcode_nodata ##1 !cs_rise
      |-> cmd_valid_o)
      else $error("addressless opcode not issued at once");
   chk_select_first: assert property (@(posedge ref_clk_i)
      disable iff (srst_i) state == ST_IDLE && !cs_fall
      |=> state == ST_IDLE)
      else $error("command started without select falling edge");
endmodule

// ### test/host_spi_model.sv
`timescale 1ns/1ps
// Host end of the serial link. The link clock has an 80 ns period and
// stands still between frames at the idle level of the chosen mode.
module host_spi_model (
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o
);
   logic idle;

   // Deselected with the clock parked high, as a host sits at power-up.
   initial
   begin
      cs_n_o = 1'b1;
      sck_o = 1'b1;
      si_o = 1'b0;
      idle = 1'b1;
   end

   // The clock is parked before select falls, so the device sees the mode.
   task automatic open_frame(input logic mode3);
      idle = mode3;
      sck_o = mode3;
      #40;
      cs_n_o = 1'b0;
      #40;
   endtask

   // Data is set while the clock is low and taken on the rise.
   task automatic put_byte(input logic [7:0] value);
      for (int i = 7; i >= 0; i--)
      begin
         sck_o = 1'b0;
         si_o = value[i];
         #40;
         sck_o = 1'b1;
         #40;
      end
   endtask

   // The data line has no pull, so it flips after release; a stale level
   // could otherwise hide a bit that was taken late.
   task automatic close_frame();
      sck_o = idle;
      #40;
      cs_n_o = 1'b1;
      si_o = ~si_o;
      #40;
   endtask
endmodule

// ### test/test_serial_flash_cmd_addr_and_power_on.sv
`timescale 1ns/1ps
module test_serial_flash_cmd_addr_and_power_on;
   import flash_front_pkg::*;
   localparam int WD = 2000;
   localparam int LIMIT = 60000;
   typedef struct packed {
      logic [7:0] op;
      logic [2:0] fl;
      logic [2:0] na;
      logic [2:0] nd;
      logic [9:0] pg;
      logic [8:0] by;
      logic [17:0] li;
   } row_type;
   // Flags are {256-byte pages, mode 3, fields checked}; address E5A5A5.
   row_type rows [22] = '{
      '{8'h03, 3'h3, 3'h3, 3'h0, 10'h2D2, 9'h1A5, 18'h1A5A5},
      '{8'h0B, 3'h1, 3'h3, 3'h1, 10'h2D2, 9'h1A5, 18'h1A5A5},
      '{8'h50, 3'h3, 3'h3, 3'h0, 10'h2D0, 9'h000, 18'h1A5A5},
      '{8'h53, 3'h3, 3'h3, 3'h0, 10'h2D2, 9'h000, 18'h1A5A5},
      '{8'h58, 3'h1, 3'h3, 3'h0, 10'h2D2, 9'h000, 18'h1A5A5},
      '{8'h60, 3'h3, 3'h3, 3'h0, 10'h2D2, 9'h000, 18'h1A5A5},
      '{8'h77, 3'h3, 3'h3, 3'h0, 10'h000, 9'h000, 18'h00000},
      '{8'h7C, 3'h3, 3'h3, 3'h0, 10'h200, 9'h000, 18'h1A5A5},
      '{8'h81, 3'h3, 3'h3, 3'h0, 10'h2D2, 9'h000, 18'h1A5A5},
      '{8'h82, 3'h3, 3'h3, 3'h0, 10'h2D2, 9'h1A5, 18'h1A5A5},
      '{8'h83, 3'h1, 3'h3, 3'h0, 10'h2D2, 9'h000, 18'h1A5A5},
      '{8'h84, 3'h3, 3'h3, 3'h0, 10'h000, 9'h1A5, 18'h1A5A5},
      '{8'h88, 3'h3, 3'h3, 3'h0, 10'h2D2, 9'h000, 18'h1A5A5},
      '{8'h9F, 3'h2, 3'h0, 3'h0, 10'h000, 9'h000, 18'h00000},
      '{8'hB9, 3'h2, 3'h0, 3'h0, 10'h000, 9'h000, 18'h00000},
      '{8'hAB, 3'h0, 3'h0, 3'h0, 10'h000, 9'h000, 18'h00000},
      '{8'hD1, 3'h3, 3'h3, 3'h0, 10'h000, 9'h1A5, 18'h1A5A5},
      '{8'hD2, 3'h3, 3'h3, 3'h4, 10'h2D2, 9'h1A5, 18'h1A5A5},
      '{8'hD4, 3'h1, 3'h3, 3'h1, 10'h000, 9'h1A5, 18'h1A5A5},
      '{8'hD7, 3'h2, 3'h0, 3'h0, 10'h000, 9'h000, 18'h00000},
      '{8'hE8, 3'h3, 3'h3, 3'h4, 10'h2D2, 9'h1A5, 18'h1A5A5},
      '{8'h03, 3'h5, 3'h3, 3'h0, 10'h1A5, 9'h0A5, 18'h1A5A5}
   };
   logic ref_clk_i = 1'b0;
   logic srst_i;
   logic page_size_256_i;
   logic sck, cs_n, si, so, so_oe_n, mode3, valid, dphase, wa, wref;
   logic [7:0] opc, cap_op;
   logic [9:0] pg, cap_pg;
   logic [8:0] by, cap_by;
   logic [17:0] li, cap_li;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int n_valid = 0;
   int n_ref = 0;
   int rel = 0;
   int wa_cap = 0;
   logic wa_seen = 1'b0;
   int v0;
   int r0;

   always #2 ref_clk_i = ~ref_clk_i;

   host_spi_model u_host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si));

   flash_cmd_front #(.WRITE_DELAY(WD)) u_dut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .sck_i(sck),
      .cs_n_i(cs_n), .si_i(si), .page_size_256_i(page_size_256_i),
      .so_o(so), .so_oe_n_o(so_oe_n), .mode3_o(mode3),
      .cmd_valid_o(valid), .opcode_o(opc), .page_o(pg), .byte_o(by),
      .linear_addr_o(li), .data_phase_o(dphase),
      .write_allowed_o(wa), .write_refused_o(wref)
   );

   task automatic complete_run();
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string s);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t %s got %b", $time, s, got);
      end
   endtask

   task automatic chk_val(input logic [17:0] got, input logic [17:0] exp,
                          input string s);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   // Pulses are short, so they are caught here and counted; the hold-off
   // is timed from each reset release.
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (valid === 1'b1)
      begin
         n_valid <= n_valid + 1;
         cap_op <= opc;
         cap_pg <= pg;
         cap_by <= by;
         cap_li <= li;
      end
      if (wref === 1'b1)
         n_ref <= n_ref + 1;
      rel <= (srst_i === 1'b1) ? 0 : rel + 1;
      if (srst_i === 1'b1)
         wa_seen <= 1'b0;
      else if (wa === 1'b1 && !wa_seen)
      begin
         wa_seen <= 1'b1;
         wa_cap <= rel;
      end
      if (cycles == LIMIT)
      begin
         miscompares++;
         complete_run();
      end
   end

   // Sends all but the last byte, proves no early decode, then the last.
   task automatic send_cmd(input row_type r);
      logic [7:0] seq [8];
      int n;
      int v;
      seq = '{r.op, 8'hE5, 8'hA5, 8'hA5, 8'h5A, 8'h5A, 8'h5A, 8'h5A};
      n = 1 + int'(r.na) + int'(r.nd);
      v = n_valid;
      u_host.open_frame(r.fl[1]);
      for (int i = 0; i < n - 1; i++)
         u_host.put_byte(seq[i]);
      #80;
      chk_val(18'(n_valid - v), 18'h0, "early decode");
      u_host.put_byte(seq[n - 1]);
      #80;
   endtask

   initial
   begin
      srst_i = 1'b1;
      page_size_256_i = 1'b0;
      repeat (10) @(negedge ref_clk_i);
      chk_bit(mode3, 1'b1, "mode after reset");
      chk_bit(so_oe_n, 1'b1, "output off");
      chk_bit(wa, 1'b0, "write gate in reset");
      chk_bit(so, 1'b0, "output data idle");
      srst_i = 1'b0;
      // No select until well after release; the supply wait is scaled down
      // so the run stays short.
      for (int i = 0; i < WD + 50 && wa !== 1'b1; i++)
         @(negedge ref_clk_i);
      // The capture of the release count lands one edge after the gate.
      @(negedge ref_clk_i);
      chk_bit(wa_cap == WD, 1'b1, "hold-off");
      foreach (rows[k])
      begin
         @(negedge ref_clk_i);
         page_size_256_i = rows[k].fl[2];
         v0 = n_valid;
         send_cmd(rows[k]);
         chk_val(18'(n_valid - v0), 18'h1, "decode");
         chk_bit(mode3, rows[k].fl[1], "mode");
         chk_bit(dphase, 1'b1, "data phase");
         chk_bit(so_oe_n, 1'b1, "output off");
         chk_val(18'(cap_op), 18'(rows[k].op), "opcode");
         if (rows[k].fl[0])
         begin
            chk_val(18'(cap_pg), 18'(rows[k].pg), "page");
            chk_val(18'(cap_by), 18'(rows[k].by), "byte");
            chk_val(cap_li, rows[k].li, "linear");
         end
         u_host.close_frame();
         chk_bit(dphase, 1'b0, "standby");
      end
      // A byte in reset, then one in a frame opened before release.
      v0 = n_valid;
      @(negedge ref_clk_i);
      srst_i = 1'b1;
      u_host.open_frame(1'b1);
      u_host.put_byte(OP_STATUS_READ);
      #80;
      chk_val(18'(n_valid - v0), 18'h0, "decode in reset");
      chk_bit(mode3, 1'b1, "mode after reset");
      chk_bit(wa, 1'b0, "write gate rearmed");
      @(negedge ref_clk_i);
      srst_i = 1'b0;
      u_host.put_byte(OP_STATUS_READ);
      #80;
      u_host.close_frame();
      chk_val(18'(n_valid - v0), 18'h0, "no select edge");
      // Erase before the hold-off ends is refused, not decoded.
      r0 = n_ref;
      send_cmd(rows[8]);
      u_host.close_frame();
      chk_val(18'(n_ref - r0), 18'h1, "refused");
      chk_val(18'(n_valid - v0), 18'h0, "refused decode");
      // Abort mid address, an unknown opcode, then a clean status read.
      u_host.open_frame(1'b0);
      u_host.put_byte(OP_ARRAY_READ);
      u_host.put_byte(8'hE5);
      u_host.close_frame();
      u_host.open_frame(1'b1);
      u_host.put_byte(8'hFF);
      u_host.close_frame();
      send_cmd(rows[19]);
      u_host.close_frame();
      chk_val(18'(n_valid - v0), 18'h1, "after abort");
      complete_run();
   end
endmodule
